// ==== include/tpl_consts.svh ====
`ifndef TPL_CONSTS_SVH
`define TPL_CONSTS_SVH

// ----------------------------------------
// Object indices
// ----------------------------------------
`define TPL_IDX_CTRL     16'h60b8
`define TPL_IDX_STATUS   16'h60b9
`define TPL_IDX_POS1     16'h60ba
`define TPL_IDX_POS2     16'h60bc

// ----------------------------------------
// Control byte fields, per unit
// ----------------------------------------
`define TPL_CB_EN        0
`define TPL_CB_CONT      1
`define TPL_CB_SRC       2
`define TPL_CB_RISE      4
`define TPL_CB_FALL      5

// ----------------------------------------
// Status byte fields, per unit
// ----------------------------------------
`define TPL_SB_EN        0
`define TPL_SB_RISE      1
`define TPL_SB_FALL      2
`define TPL_SB_TOG       7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TPL_CTRL_RST     16'h0000
`define TPL_BYTE_RST     8'h00
`define TPL_POS_RST      32'h0000_0000

`endif

// ==== include/tpl_pkg.sv ====
package tpl_pkg;
  typedef logic [7:0]  tpl_byte_type;
  typedef logic [15:0] tpl_word_type;
  typedef logic [31:0] tpl_pos_type;
endpackage

// ==== include/tpl_probe_if.sv ====
`timescale 1ns/1ps
interface tpl_probe_if;
  import tpl_pkg::*;
  tpl_byte_type ctrl;
  logic         arm;
  logic         rise_evt;
  logic         fall_evt;
  tpl_pos_type  pos;
  tpl_byte_type status;
  tpl_pos_type  cap_pos;
  logic         cap_pulse;

  modport unit (input ctrl, arm, rise_evt, fall_evt, pos, output status, cap_pos, cap_pulse);
  modport top  (output ctrl, arm, rise_evt, fall_evt, pos, input status, cap_pos, cap_pulse);
endinterface

// ==== rtl/tpl_sync.sv ====
`timescale 1ns/1ps
module tpl_sync (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // Pin levels in and out
  input  wire logic [2:0] async_in,
  output logic      [2:0] sync_out
);
  logic [2:0] meta_ff;
  logic [2:0] sync_ff;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= 3'h0;
      sync_ff <= 3'h0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule

// ==== rtl/tpl_probe_unit.sv ====
`timescale 1ns/1ps
`include "tpl_consts.svh"
module tpl_probe_unit (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // Probe channel
  tpl_probe_if.unit pu
);
  import tpl_pkg::*;

  logic        done_ff;
  logic        rise_st_ff;
  logic        fall_st_ff;
  logic        tog_ff;
  tpl_pos_type cap_ff;
  logic        hit_rise;
  logic        hit_fall;
  logic        hit;

  // ----------------------------------------
  // Qualify events
  // ----------------------------------------
  assign hit_rise = pu.ctrl[`TPL_CB_EN] & pu.ctrl[`TPL_CB_RISE] & pu.rise_evt;
  assign hit_fall = pu.ctrl[`TPL_CB_EN] & pu.ctrl[`TPL_CB_FALL] & pu.fall_evt;
  // Single mode takes only the first event since arming
  assign hit      = (hit_rise | hit_fall) & (pu.ctrl[`TPL_CB_CONT] | ~done_ff); // RL15 RL16

  // ----------------------------------------
  // Capture and flags; capture beats re-arm
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cap_ff <= `TPL_POS_RST;
    end else if (hit) begin
      cap_ff <= pu.pos; // RL1
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      done_ff    <= 1'b0;
      rise_st_ff <= 1'b0;
      fall_st_ff <= 1'b0;
    end else if (hit) begin
      done_ff    <= 1'b1; // RL15
      rise_st_ff <= rise_st_ff | hit_rise;
      fall_st_ff <= fall_st_ff | hit_fall;
    end else if (pu.arm || !pu.ctrl[`TPL_CB_EN]) begin
      done_ff    <= 1'b0;
      rise_st_ff <= 1'b0;
      fall_st_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tog_ff <= 1'b0;
    end else if (hit) begin
      tog_ff <= ~tog_ff; // RL16
    end
  end

  assign pu.cap_pulse = hit;
  assign pu.cap_pos   = cap_ff;
  assign pu.status    = {tog_ff, 4'h0, fall_st_ff, rise_st_ff, pu.ctrl[`TPL_CB_EN]};
endmodule

// ==== rtl/tpl_touch_probe.sv ====
`timescale 1ns/1ps
`include "tpl_consts.svh"
// Function
// RL1 - A trigger event stores the current feedback position in that unit's register.
// RL2 - Two independent capture units, usable at the same time.
// RL3 - Unit one control is the low byte of the control word.
// RL4 - Unit one status is the low byte of the status word.
// RL5 - Unit one captures always land in the unit one position register.
// RL6 - Unit one triggers on encoder zero pulse or first latch input.
// RL7 - Unit two control is the high byte of the control word.
// RL8 - Unit two status is the high byte of the status word.
// RL9 - Unit two captures always land in the unit two position register.
// RL10 - Unit two triggers only on the second latch input.
// RL11 - Homing disables unit one and switches it off if active.
// RL12 - Master clears bit 1 or bit 9 for single trigger.
// RL13 - Master sets bit 1 or bit 9 for continuous trigger.
// RL14 - Each latch input polarity is chosen by its own config digit.
// RL15 - Single mode captures the first event only, until re-armed.
// RL16 - Continuous mode captures every event and flags each capture.
module tpl_touch_probe (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  // Latch pins and encoder
  input  wire logic                 first_probe_latch_input,
  input  wire logic                 second_probe_latch_input,
  input  wire logic                 enc_zero_pulse,
  input  wire tpl_pkg::tpl_pos_type feedback_position,
  // Drive state and configuration
  input  wire logic                 homing_active,
  input  wire logic [1:0]           probe_input_config_parameter,
  // Object access
  input  wire logic                 obj_req,
  input  wire logic                 obj_we,
  input  wire tpl_pkg::tpl_word_type obj_index,
  input  wire tpl_pkg::tpl_pos_type obj_wdata,
  output logic                      obj_ack,
  output logic                      obj_err,
  output tpl_pkg::tpl_pos_type      obj_rdata
);
  import tpl_pkg::*;

  tpl_probe_if u1 ();
  tpl_probe_if u2 ();

  logic [2:0]   pin_sync;
  logic         p1_act;
  logic         p2_act;
  logic         p1_prev_ff;
  logic         p2_prev_ff;
  logic         zp_prev_ff;
  logic         p1_rise;
  logic         p1_fall;
  logic         p2_rise;
  logic         p2_fall;
  logic         zp_rise;
  logic         zp_fall;
  tpl_word_type ctrl_ff;
  tpl_word_type nxt_ctrl;
  logic         wr_ctrl;
  logic         obj_ack_ff;
  logic         obj_err_ff;
  tpl_pos_type  obj_rdata_ff;
  tpl_pos_type  nxt_rdata;
  logic         nxt_err;
  logic [2:0]   warm_ff;
  logic         warm;

  function automatic logic edge_up(input logic cur, input logic prev);
    edge_up = cur & ~prev;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  tpl_sync u_sync (
    .mclk     (mclk),
    .rstn     (rstn),
    .async_in ({enc_zero_pulse, second_probe_latch_input, first_probe_latch_input}),
    .sync_out (pin_sync)
  );

  // ----------------------------------------
  // Settle after reset
  // ----------------------------------------
  // Edges masked until synchroniser and history hold real levels,
  // else an inverted idle pin fires a false edge after reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      warm_ff <= 3'h0;
    end else begin
      warm_ff <= {warm_ff[1:0], 1'b1};
    end
  end

  assign warm = warm_ff[2];

  // ----------------------------------------
  // Polarity and edge detect
  // ----------------------------------------
  // Config digit set means the pin is active low
  assign p1_act = pin_sync[0] ^ probe_input_config_parameter[0]; // RL14
  assign p2_act = pin_sync[1] ^ probe_input_config_parameter[1]; // RL14

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      p1_prev_ff <= 1'b0;
      p2_prev_ff <= 1'b0;
      zp_prev_ff <= 1'b0;
    end else begin
      p1_prev_ff <= p1_act;
      p2_prev_ff <= p2_act;
      zp_prev_ff <= pin_sync[2];
    end
  end

  assign p1_rise = warm & edge_up(p1_act, p1_prev_ff);
  assign p1_fall = warm & edge_up(p1_prev_ff, p1_act);
  assign p2_rise = warm & edge_up(p2_act, p2_prev_ff);
  assign p2_fall = warm & edge_up(p2_prev_ff, p2_act);
  assign zp_rise = warm & edge_up(pin_sync[2], zp_prev_ff);
  assign zp_fall = warm & edge_up(zp_prev_ff, pin_sync[2]);

  // ----------------------------------------
  // Control word
  // ----------------------------------------
  assign wr_ctrl = obj_req & obj_we & (obj_index == `TPL_IDX_CTRL);

  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl = obj_wdata[15:0]; // RL3 RL7
    end
    // Unit one stays off for the whole homing run
    if (homing_active) begin
      nxt_ctrl[`TPL_CB_EN] = 1'b0; // RL11
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= `TPL_CTRL_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // ----------------------------------------
  // Probe units
  // ----------------------------------------
  assign u1.ctrl     = {ctrl_ff[7:1], ctrl_ff[`TPL_CB_EN] & ~homing_active}; // RL3 RL11
  assign u1.arm      = wr_ctrl;
  // Source bit picks encoder zero pulse or first latch input
  assign u1.rise_evt = ctrl_ff[`TPL_CB_SRC] ? zp_rise : p1_rise; // RL6
  assign u1.fall_evt = ctrl_ff[`TPL_CB_SRC] ? zp_fall : p1_fall; // RL6
  assign u1.pos      = feedback_position;

  assign u2.ctrl     = ctrl_ff[15:8]; // RL7
  assign u2.arm      = wr_ctrl;
  assign u2.rise_evt = p2_rise; // RL10
  assign u2.fall_evt = p2_fall; // RL10
  assign u2.pos      = feedback_position;

  // Separate instances share only clock, reset, the position input and the arm strobe
  tpl_probe_unit u_unit1 ( // RL2
    .mclk (mclk),
    .rstn (rstn),
    .pu   (u1.unit)
  );

  tpl_probe_unit u_unit2 ( // RL2
    .mclk (mclk),
    .rstn (rstn),
    .pu   (u2.unit)
  );

  // ----------------------------------------
  // Object read and answer
  // ----------------------------------------
  always_comb begin
    nxt_rdata = `TPL_POS_RST;
    nxt_err   = 1'b0;
    case (obj_index)
      `TPL_IDX_CTRL: begin
        nxt_rdata = {16'h0000, ctrl_ff};
      end
      `TPL_IDX_STATUS: begin
        nxt_rdata = {16'h0000, u2.status, u1.status}; // RL4 RL8
        nxt_err   = obj_we;
      end
      `TPL_IDX_POS1: begin
        nxt_rdata = u1.cap_pos; // RL5
        nxt_err   = obj_we;
      end
      `TPL_IDX_POS2: begin
        nxt_rdata = u2.cap_pos; // RL9
        nxt_err   = obj_we;
      end
      default: begin
        nxt_err   = 1'b1;
      end
    endcase
    if (obj_we) begin
      nxt_rdata = `TPL_POS_RST;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      obj_ack_ff   <= 1'b0;
      obj_err_ff   <= 1'b0;
      obj_rdata_ff <= `TPL_POS_RST;
    end else begin
      obj_ack_ff   <= obj_req;
      obj_err_ff   <= obj_req & nxt_err;
      obj_rdata_ff <= obj_req ? nxt_rdata : `TPL_POS_RST;
    end
  end

  assign obj_ack   = obj_ack_ff;
  assign obj_err   = obj_err_ff;
  assign obj_rdata = obj_rdata_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_cap1_pos;
    @(posedge mclk) disable iff (!rstn)
      u1.cap_pulse |=> (u1.cap_pos == $past(feedback_position));
  endproperty
  a_cap1_pos: assert property (p_cap1_pos) else $error("unit one position not captured"); // RL1 RL5

  property p_cap2_pos;
    @(posedge mclk) disable iff (!rstn)
      u2.cap_pulse |=> (u2.cap_pos == $past(feedback_position));
  endproperty
  a_cap2_pos: assert property (p_cap2_pos) else $error("unit two position not captured"); // RL9

  property p_ctrl_lo;
    @(posedge mclk) disable iff (!rstn)
      (wr_ctrl && !homing_active) |=> (ctrl_ff[7:0] == $past(obj_wdata[7:0]));
  endproperty
  a_ctrl_lo: assert property (p_ctrl_lo) else $error("unit one control byte wrong"); // RL3

  property p_ctrl_hi;
    @(posedge mclk) disable iff (!rstn)
      wr_ctrl |=> (u2.ctrl == $past(obj_wdata[15:8]));
  endproperty
  a_ctrl_hi: assert property (p_ctrl_hi) else $error("unit two control byte wrong"); // RL7

  property p_stat_lo;
    @(posedge mclk) disable iff (!rstn)
      (obj_req && !obj_we && obj_index == `TPL_IDX_STATUS) |=> (obj_rdata[7:0] == $past(u1.status));
  endproperty
  a_stat_lo: assert property (p_stat_lo) else $error("unit one status byte wrong"); // RL4

  property p_stat_hi;
    @(posedge mclk) disable iff (!rstn)
      (obj_req && !obj_we && obj_index == `TPL_IDX_STATUS) |=> (obj_rdata[15:8] == $past(u2.status));
  endproperty
  a_stat_hi: assert property (p_stat_hi) else $error("unit two status byte wrong"); // RL8

  property p_src1;
    @(posedge mclk) disable iff (!rstn)
      u1.cap_pulse |-> (ctrl_ff[`TPL_CB_SRC] ? (zp_rise || zp_fall) : (p1_rise || p1_fall));
  endproperty
  a_src1: assert property (p_src1) else $error("unit one fired from wrong source"); // RL6

  property p_src2;
    @(posedge mclk) disable iff (!rstn)
      u2.cap_pulse |-> (p2_rise || p2_fall);
  endproperty
  a_src2: assert property (p_src2) else $error("unit two fired without its input"); // RL10

  property p_homing;
    @(posedge mclk) disable iff (!rstn)
      $rose(homing_active) |-> !u1.cap_pulse ##1 (!ctrl_ff[`TPL_CB_EN] && !u1.status[`TPL_SB_EN]);
  endproperty
  a_homing: assert property (p_homing) else $error("unit one not switched off by homing"); // RL11

  property p_single;
    @(posedge mclk) disable iff (!rstn)
      (u1.cap_pulse && !u1.ctrl[`TPL_CB_CONT] && !u1.arm) ##1 (!u1.arm && !u1.ctrl[`TPL_CB_CONT])[*2]
        |-> !u1.cap_pulse;
  endproperty
  a_single: assert property (p_single) else $error("single mode captured twice"); // RL15

  property p_cont;
    @(posedge mclk) disable iff (!rstn)
      (u2.cap_pulse && u2.ctrl[`TPL_CB_CONT]) |=> (u2.status[`TPL_SB_TOG] != $past(u2.status[`TPL_SB_TOG]));
  endproperty
  a_cont: assert property (p_cont) else $error("continuous capture not flagged"); // RL16

  property p_cont_every;
    @(posedge mclk) disable iff (!rstn)
      (u2.ctrl[`TPL_CB_EN] && u2.ctrl[`TPL_CB_CONT] && u2.ctrl[`TPL_CB_RISE] && p2_rise) |-> u2.cap_pulse;
  endproperty
  a_cont_every: assert property (p_cont_every) else $error("continuous mode missed an event"); // RL16

  property p_home_quiet;
    @(posedge mclk) disable iff (!rstn)
      homing_active |-> !u1.cap_pulse;
  endproperty
  a_home_quiet: assert property (p_home_quiet) else $error("unit one captured during homing"); // RL11

  property p_rearm;
    @(posedge mclk) disable iff (!rstn)
      (u1.arm && !u1.cap_pulse) |=> (u1.status[`TPL_SB_FALL:`TPL_SB_RISE] == 2'b00);
  endproperty
  a_rearm: assert property (p_rearm) else $error("unit one flags kept after re-arm"); // RL15

endmodule

// ==== bench/tpl_master_model.sv ====
`timescale 1ns/1ps
module tpl_master_model (
  // Clock
  input  wire logic                 mclk,
  // Object access
  output logic                      obj_req,
  output logic                      obj_we,
  output tpl_pkg::tpl_word_type     obj_index,
  output tpl_pkg::tpl_pos_type      obj_wdata,
  input  wire logic                 obj_ack,
  input  wire logic                 obj_err,
  input  wire tpl_pkg::tpl_pos_type obj_rdata
);
  import tpl_pkg::*;

  initial begin
    obj_req   = 1'b0;
    obj_we    = 1'b0;
    obj_index = 16'h0000;
    obj_wdata = 32'h0000_0000;
  end

  // ----------------------------------------
  // One access, taken at the rising edge
  // ----------------------------------------
  // Idle fields show the inverse of the last value
  task automatic xfer(input logic we, input tpl_word_type idx, input tpl_pos_type wd,
                      output tpl_pos_type rd, output logic err, output logic ack);
    @(negedge mclk);
    obj_req   <= 1'b1;
    obj_we    <= we;
    obj_index <= idx;
    obj_wdata <= wd;
    // Answer stands only between the taking edge and the next one
    @(negedge mclk);
    rd  = obj_rdata;
    err = obj_err;
    ack = obj_ack;
    obj_req   <= 1'b0;
    obj_we    <= ~we;
    obj_index <= ~idx;
    obj_wdata <= ~wd;
  endtask
endmodule

// ==== bench/tb_touch_probe_position_latch.sv ====
`timescale 1ns/1ps
`include "tpl_consts.svh"
module tb_touch_probe_position_latch;
  import tpl_pkg::*;

  logic         mclk, rstn, p1, p2, ez, hom, req, we, ack, err;
  logic [1:0]   cfg;
  tpl_pos_type  fpos, wd, rd;
  tpl_word_type idx;
  int           n_mismatch, compares;

  tpl_touch_probe dut (
    .mclk(mclk), .rstn(rstn),
    .first_probe_latch_input(p1), .second_probe_latch_input(p2),
    .enc_zero_pulse(ez), .feedback_position(fpos),
    .homing_active(hom), .probe_input_config_parameter(cfg),
    .obj_req(req), .obj_we(we), .obj_index(idx), .obj_wdata(wd),
    .obj_ack(ack), .obj_err(err), .obj_rdata(rd)
  );

  tpl_master_model mdl (
    .mclk(mclk), .obj_req(req), .obj_we(we), .obj_index(idx), .obj_wdata(wd),
    .obj_ack(ack), .obj_err(err), .obj_rdata(rd)
  );

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input string nm, input tpl_pos_type seen, input tpl_pos_type exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    if (n_mismatch == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic acc(input logic w, input tpl_word_type i, input tpl_pos_type d,
                     input logic xerr, input tpl_pos_type xrd, input string nm);
    tpl_pos_type r;
    logic        e, a;
    mdl.xfer(w, i, d, r, e, a);
    chk({nm, " resp"}, 32'({a, e}), 32'({1'b1, xerr}));
    chk(nm, r, xrd);
  endtask

  // Pin active holds pos, release shows ~pos
  task automatic pulse(input int wh, input tpl_pos_type pos);
    @(negedge mclk);
    fpos <= pos;
    if (wh == 1) p1 <= ~cfg[0];
    if (wh == 2) p2 <= ~cfg[1];
    if (wh == 3) ez <= 1'b1;
    repeat (5) @(negedge mclk);
    fpos <= ~pos;
    p1   <= cfg[0];
    p2   <= cfg[1];
    ez   <= 1'b0;
    repeat (5) @(negedge mclk);
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    #50000;
    n_mismatch++;
    results();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rstn = 1'b0; p1 = 1'b0; p2 = 1'b0; ez = 1'b0; hom = 1'b0;
    cfg = 2'b00; fpos = 32'h0000_0000; n_mismatch = 0; compares = 0;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'b1;
    acc(0, `TPL_IDX_CTRL, 0, 0, 0, "ctrl");
    acc(0, `TPL_IDX_STATUS, 0, 0, 0, "status");
    acc(0, `TPL_IDX_POS1, 0, 0, 0, "pos1");
    acc(0, `TPL_IDX_POS2, 0, 0, 0, "pos2");
    acc(0, 16'h60bb, 0, 1, 0, "unmapped");
    acc(1, `TPL_IDX_STATUS, 32'hffff, 1, 0, "ro");
    acc(1, `TPL_IDX_CTRL, 32'h1311, 0, 0, "wr");
    acc(0, `TPL_IDX_CTRL, 0, 0, 32'h1311, "ctrl");
    pulse(2, 32'h1111_1111);
    acc(0, `TPL_IDX_POS2, 0, 0, 32'h1111_1111, "pos2");
    acc(0, `TPL_IDX_STATUS, 0, 0, 32'h8301, "status");
    pulse(2, 32'h2222_2222);
    acc(0, `TPL_IDX_POS2, 0, 0, 32'h2222_2222, "pos2");
    acc(0, `TPL_IDX_STATUS, 0, 0, 32'h0301, "status");
    pulse(3, 32'h3333_3333);
    acc(0, `TPL_IDX_POS2, 0, 0, 32'h2222_2222, "pos2");
    acc(0, `TPL_IDX_POS1, 0, 0, 0, "pos1");
    pulse(1, 32'h4444_4444);
    acc(0, `TPL_IDX_POS1, 0, 0, 32'h4444_4444, "pos1");
    acc(0, `TPL_IDX_STATUS, 0, 0, 32'h0383, "status");
    pulse(1, 32'h5555_5555);
    acc(0, `TPL_IDX_POS1, 0, 0, 32'h4444_4444, "pos1");
    acc(1, `TPL_IDX_CTRL, 32'h0015, 0, 0, "wr");
    acc(0, `TPL_IDX_STATUS, 0, 0, 32'h0081, "status");
    pulse(3, 32'h6666_6666);
    acc(0, `TPL_IDX_POS1, 0, 0, 32'h6666_6666, "pos1");
    acc(0, `TPL_IDX_STATUS, 0, 0, 32'h0003, "status");
    pulse(1, 32'h7777_7777);
    acc(0, `TPL_IDX_POS1, 0, 0, 32'h6666_6666, "pos1");
    // Unit two idle while the pin polarity flips
    @(negedge mclk);
    cfg <= 2'b10;
    p2  <= 1'b1;
    repeat (6) @(negedge mclk);
    acc(1, `TPL_IDX_CTRL, 32'h2300, 0, 0, "wr");
    pulse(2, 32'h8888_8888);
    acc(0, `TPL_IDX_POS2, 0, 0, 32'h7777_7777, "pos2");
    acc(0, `TPL_IDX_STATUS, 0, 0, 32'h8500, "status");
    acc(1, `TPL_IDX_CTRL, 32'h0011, 0, 0, "wr");
    @(negedge mclk);
    hom <= 1'b1;
    pulse(1, 32'h9999_9999);
    acc(0, `TPL_IDX_POS1, 0, 0, 32'h6666_6666, "pos1");
    acc(0, `TPL_IDX_STATUS, 0, 0, 32'h8000, "status");
    @(negedge mclk);
    hom <= 1'b0;
    acc(0, `TPL_IDX_CTRL, 0, 0, 32'h0010, "ctrl");
    results();
  end
endmodule
